// ==== logic/cfa_fault_abort.sv ====
// canopen communication fault detection and sdo abort code selection
//
// Our own choices: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ns
// Operation
// RULE_01 - guard or heartbeat time expired: fault
// RULE_02 - nmt reset while enabled: fault
// RULE_03 - nmt stop while enabled: fault
// RULE_04 - excessive bus errors: disconnect fault
// RULE_05 - pdo length differs from mapping: fault
// RULE_06 - lower limit above upper limit: fault
// RULE_07 - home offset outside open limits: fault
// RULE_08 - sync interval off over quarter: fault
// RULE_09 - master sends sync at configured period
// RULE_10 - toggle not alternated: abort 0503_0000
// RULE_11 - sdo timeout: abort 0504_0000
// RULE_12 - bad command specifier: abort 0504_0001
// RULE_13 - access faults: abort 0601_000x
// RULE_14 - missing index or subindex codes
// RULE_15 - pdo mapping abort codes
// RULE_16 - data length mismatch codes
// RULE_17 - value invalid, high or low
// RULE_18 - max below min: abort 0609_0036
// RULE_19 - parameter or device incompatibility codes
// RULE_20 - hardware error or memory overflow
// RULE_21 - cannot store, local, state codes
// RULE_22 - general, dictionary, no value codes
// RULE_23 - guard fault code 8130, resettable
// RULE_24 - init fault code 8160, not resettable
// RULE_25 - disconnect fault code 8141, resettable
// RULE_26 - pdo fault code 8210, resettable
// RULE_27 - abort returns code, ends transfer
// RULE_28 - one code, fixed priority order
module cfa_fault_abort
	import cfa_pkg::*;
#(
	parameter int TICK_LEN = TICK_CYCLES
)
(
	input wire logic clock,
	input wire logic resetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// node events, same clock domain
	input wire logic motorEnabled,
	input wire logic nmtResetCmd,
	input wire logic nmtStopCmd,
	input wire logic guardMsg,
	input wire logic heartbeatMsg,
	input wire logic busErrorEvt,
	input wire logic busOkEvt,
	input wire logic pdoRxValid,
	input wire logic [3:0] pdoRxLen,
	input wire logic [1:0] pdoRxNum,
	input wire logic syncEvt,
	// sdo request side
	input wire logic sdoStart,
	input wire logic sdoSegment,
	input wire logic sdoToggle,
	input wire logic sdoDone,
	input wire logic sdoCheck,
	input wire logic [NUM_SC-1:0] sdoCond,
	output logic sdoAbort,
	output logic [31:0] sdoAbortCode,
	output logic sdoBusy,
	output logic [NUM_FAULTS-1:0] faultFlags,
	output logic [15:0] errorCode
);

	logic rstMeta_r, rstSync_r, rst;
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			rstMeta_r <= 1'b0;
			rstSync_r <= 1'b0;
		end
		else
		begin
			rstMeta_r <= 1'b1;
			rstSync_r <= rstMeta_r;
		end
	end
	assign rst = !rstSync_r;

	////////////////////////////////////////////////////////////////////////
	logic dataPhase_r, dataWrite_r;
	logic [7:0] dataAddr_r;
	logic [31:0] guardMs_r, hbeatMs_r, syncPerMs_r, limLo_r, limHi_r, home_r, sdoTmoMs_r;
	logic [7:0] busErrLimit_r;
	logic [15:0] pdoMapLen_r;
	logic [NUM_FAULTS-1:0] fault_r, faultSet, faultClr;
	logic [31:0] abortCode_r;
	logic wrEn;

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign wrEn = dataPhase_r && dataWrite_r;

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			dataPhase_r <= 1'b0;
			dataWrite_r <= 1'b0;
			dataAddr_r <= 8'h00;
		end
		else if (hready)
		begin
			dataPhase_r <= hsel && htrans == HTRANS_NONSEQ;
			dataWrite_r <= hwrite;
			dataAddr_r <= haddr;
		end
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			guardMs_r <= RST_ZERO;
			hbeatMs_r <= RST_ZERO;
			syncPerMs_r <= RST_ZERO;
			limLo_r <= RST_ZERO;
			limHi_r <= RST_ZERO;
			home_r <= RST_ZERO;
			sdoTmoMs_r <= RST_ZERO;
			busErrLimit_r <= RST_BUSERR;
			pdoMapLen_r <= 16'h0000;
		end
		else if (wrEn)
		begin
			unique case (dataAddr_r)
				OFS_GUARD: guardMs_r <= hwdata;
				OFS_HBEAT: hbeatMs_r <= hwdata;
				OFS_BUSERR: busErrLimit_r <= hwdata[7:0];
				OFS_PDOMAP: pdoMapLen_r <= hwdata[15:0];
				OFS_SYNCPER: syncPerMs_r <= hwdata;
				OFS_LIMLO: limLo_r <= hwdata;
				OFS_LIMHI: limHi_r <= hwdata;
				OFS_HOME: home_r <= hwdata;
				OFS_SDOTMO: sdoTmoMs_r <= hwdata;
				default: ;
			endcase
		end
	end

	// write one to clear; the non-resettable bits ignore software
	always_comb
	begin
		faultClr = '0;
		if (wrEn && dataAddr_r == OFS_FAULT)
			faultClr = hwdata[NUM_FAULTS-1:0] & ~FAULT_STICKY;
	end

	always_comb
	begin
		hrdata = 32'h0000_0000;
		if (dataPhase_r && !dataWrite_r)
		begin
			unique case (dataAddr_r)
				OFS_GUARD: hrdata = guardMs_r;
				OFS_HBEAT: hrdata = hbeatMs_r;
				OFS_BUSERR: hrdata = {24'h00_0000, busErrLimit_r};
				OFS_PDOMAP: hrdata = {16'h0000, pdoMapLen_r};
				OFS_SYNCPER: hrdata = syncPerMs_r;
				OFS_LIMLO: hrdata = limLo_r;
				OFS_LIMHI: hrdata = limHi_r;
				OFS_HOME: hrdata = home_r;
				OFS_FAULT: hrdata = {24'h00_0000, fault_r};
				OFS_ERRCODE: hrdata = {16'h0000, errorCode};
				OFS_ABORT: hrdata = abortCode_r;
				OFS_SDOTMO: hrdata = sdoTmoMs_r;
				default: hrdata = 32'h0000_0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// shared millisecond tick keeps the guard, heartbeat and sdo timers narrow
	logic [15:0] tickCnt_r;
	logic tick;
	assign tick = tickCnt_r == 16'(TICK_LEN - 1);
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			tickCnt_r <= 16'h0000;
		else if (tick)
			tickCnt_r <= 16'h0000;
		else
			tickCnt_r <= tickCnt_r + 16'h0001;
	end

	// zero time disables a watchdog and holds its count at zero, so enabling cannot fire at once
	logic [31:0] guardCnt_r, hbeatCnt_r;
	logic guardExp, hbeatExp;
	assign guardExp = guardMs_r != 32'h0000_0000 && guardCnt_r >= guardMs_r;
	assign hbeatExp = hbeatMs_r != 32'h0000_0000 && hbeatCnt_r >= hbeatMs_r;
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			guardCnt_r <= RST_ZERO;
			hbeatCnt_r <= RST_ZERO;
		end
		else
		begin
			if (guardMsg || guardExp || guardMs_r == RST_ZERO)
				guardCnt_r <= RST_ZERO;
			else if (tick)
				guardCnt_r <= guardCnt_r + 32'h0000_0001;
			if (heartbeatMsg || hbeatExp || hbeatMs_r == RST_ZERO)
				hbeatCnt_r <= RST_ZERO;
			else if (tick)
				hbeatCnt_r <= hbeatCnt_r + 32'h0000_0001;
		end
	end

	// bus error count: errors up, good frames down
	logic [7:0] busErrCnt_r;
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			busErrCnt_r <= 8'h00;
		else if (busErrorEvt && busErrCnt_r != 8'hFF)
			busErrCnt_r <= busErrCnt_r + 8'h01;
		else if (busOkEvt && !busErrorEvt && busErrCnt_r != 8'h00)
			busErrCnt_r <= busErrCnt_r - 8'h01;
	end

	// sync interval measured in clock cycles against the period in ms
	logic [31:0] syncCnt_r, syncMeas_r;
	logic syncSeen_r, syncCheck_r;
	logic [39:0] perCyc, devCyc, quarter;
	assign perCyc = 40'(syncPerMs_r) * 40'(TICK_LEN);
	assign quarter = perCyc >> 2;
	assign devCyc = 40'(syncMeas_r) > perCyc ? 40'(syncMeas_r) - perCyc : perCyc - 40'(syncMeas_r);
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			syncCnt_r <= RST_ZERO;
			syncMeas_r <= RST_ZERO;
			syncSeen_r <= 1'b0;
			syncCheck_r <= 1'b0;
		end
		else
		begin
			syncCheck_r <= syncEvt && syncSeen_r;
			if (syncEvt)
			begin
				syncSeen_r <= 1'b1;
				syncMeas_r <= syncCnt_r + 32'h0000_0001;
				syncCnt_r <= RST_ZERO;
			end
			else if (syncCnt_r != 32'hFFFF_FFFF)
				syncCnt_r <= syncCnt_r + 32'h0000_0001;
		end
	end

	////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		faultSet = '0;
		// RULE_01 guard heartbeat watchdog
		faultSet[FB_GUARD] = guardExp || hbeatExp;
		// RULE_02 reset while enabled
		faultSet[FB_INIT] = nmtResetCmd && motorEnabled;
		// RULE_03 stop while enabled
		faultSet[FB_STOP] = nmtStopCmd && motorEnabled;
		// RULE_04 error count limit
		faultSet[FB_NET] = busErrCnt_r >= busErrLimit_r;
		// RULE_05 pdo length check
		faultSet[FB_PDO] = pdoRxValid && pdoRxLen != pdoMapLen_r[4*pdoRxNum +: 4];
		// RULE_06 limit order check
		faultSet[FB_LIM] = $signed(limLo_r) > $signed(limHi_r);
		// RULE_07 home inside limits
		faultSet[FB_HOME] = !($signed(home_r) > $signed(limLo_r) && $signed(home_r) < $signed(limHi_r));
		// RULE_08 sync drift over quarter; RULE_09 master keeps period
		faultSet[FB_SYNC] = syncCheck_r && syncPerMs_r != 32'h0000_0000 && devCyc > quarter;
	end

	// set wins over clear
	// RULE_23 resettable guard fault; RULE_24 init fault sticky
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			fault_r <= '0;
		else
			fault_r <= (fault_r & ~faultClr) | faultSet;
	end
	assign faultFlags = fault_r;

	// highest-priority active fault drives the error code
	// RULE_25 disconnect code; RULE_26 pdo code
	always_comb
	begin
		errorCode = 16'h0000;
		if (fault_r[FB_INIT])
			errorCode = EC_INIT;
		else if (fault_r[FB_STOP])
			errorCode = EC_STOP;
		else if (fault_r[FB_NET])
			errorCode = EC_NET;
		else if (fault_r[FB_GUARD])
			errorCode = EC_GUARD;
		else if (fault_r[FB_PDO])
			errorCode = EC_PDO;
		else if (fault_r[FB_LIM] || fault_r[FB_HOME] || fault_r[FB_SYNC])
			errorCode = EC_SETTING;
	end

	////////////////////////////////////////////////////////////////////////
	// RULE_28 first set condition wins
	function automatic logic [31:0] pickAbort(input logic [NUM_SC-1:0] c);
		logic [31:0] tbl [NUM_SC];
		logic [31:0] code;
		tbl = '{AB_CMD, AB_TOGGLE, AB_NO_OBJ, AB_NO_SUB, AB_ACCESS, AB_RD_WO, AB_WR_RO,
			AB_NOMAP, AB_MAPLEN, AB_LEN, AB_LONG, AB_SHORT, AB_VALUE, AB_HIGH, AB_LOW,
			AB_MAXMIN, AB_PARAM, AB_DEVICE, AB_HW, AB_MEM, AB_STORE, AB_LOCAL, AB_STATE,
			AB_OD, AB_NOVAL, AB_GENERAL};
		code = AB_GENERAL;
		for (int i = NUM_SC - 1; i >= 0; i--)
			if (c[i])
				code = tbl[i];
		return code;
	endfunction

	cfa_sdo_state_t sdoState_r;
	logic lastToggle_r, segSeen_r, sdoTmo;
	logic [31:0] sdoMs_r;
	logic [NUM_SC-1:0] cond;
	assign sdoTmo = sdoState_r == SDO_BUSY && sdoTmoMs_r != 32'h0000_0000 && sdoMs_r >= sdoTmoMs_r;

	always_comb
	begin
		cond = sdoCond;
		// RULE_10 toggle must alternate
		cond[SC_TOGGLE] = sdoCond[SC_TOGGLE] || (sdoSegment && segSeen_r && sdoToggle == lastToggle_r);
	end

	// abort when a checked request or a segment has any condition, or on timeout
	logic reqFail;
	assign reqFail = (sdoCheck || sdoSegment) && |cond;

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			sdoState_r <= SDO_IDLE;
			sdoMs_r <= RST_ZERO;
			lastToggle_r <= 1'b0;
			segSeen_r <= 1'b0;
			abortCode_r <= RST_ZERO;
		end
		else
		begin
			unique case (sdoState_r)
				SDO_IDLE:
				begin
					sdoMs_r <= RST_ZERO;
					segSeen_r <= 1'b0;
					if (sdoStart)
						sdoState_r <= SDO_BUSY;
				end
				SDO_BUSY:
				begin
					if (sdoStart || sdoSegment)
						sdoMs_r <= RST_ZERO;
					else if (tick)
						sdoMs_r <= sdoMs_r + 32'h0000_0001;
					if (sdoSegment)
					begin
						lastToggle_r <= sdoToggle;
						segSeen_r <= 1'b1;
					end
					// RULE_11 protocol timeout
					if (sdoTmo)
					begin
						abortCode_r <= AB_TIMEOUT;
						sdoState_r <= SDO_ABORT;
					end
					// RULE_12 RULE_13 RULE_14 RULE_15 RULE_16 coded checks
					// RULE_17 RULE_18 RULE_19 RULE_20 RULE_21 RULE_22 coded checks
					else if (reqFail)
					begin
						abortCode_r <= pickAbort(cond);
						sdoState_r <= SDO_ABORT;
					end
					else if (sdoDone)
						sdoState_r <= SDO_IDLE;
				end
				// RULE_27 abort ends transfer
				SDO_ABORT: sdoState_r <= SDO_IDLE;
			endcase
		end
	end

	assign sdoAbort = sdoState_r == SDO_ABORT;
	assign sdoAbortCode = abortCode_r;
	assign sdoBusy = sdoState_r == SDO_BUSY;
endmodule

// ==== logic/cfa_pkg.sv ====
// constants for the canopen fault and sdo abort block
package cfa_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_GUARD = 8'h04;
	localparam logic [7:0] OFS_HBEAT = 8'h08;
	localparam logic [7:0] OFS_BUSERR = 8'h0C;
	localparam logic [7:0] OFS_PDOMAP = 8'h10;
	localparam logic [7:0] OFS_SYNCPER = 8'h14;
	localparam logic [7:0] OFS_LIMLO = 8'h18;
	localparam logic [7:0] OFS_LIMHI = 8'h1C;
	localparam logic [7:0] OFS_HOME = 8'h20;
	localparam logic [7:0] OFS_FAULT = 8'h24;
	localparam logic [7:0] OFS_ERRCODE = 8'h28;
	localparam logic [7:0] OFS_ABORT = 8'h2C;
	localparam logic [7:0] OFS_SDOTMO = 8'h30;
	// fault bit positions
	localparam int FB_GUARD = 0;
	localparam int FB_INIT = 1;
	localparam int FB_STOP = 2;
	localparam int FB_NET = 3;
	localparam int FB_PDO = 4;
	localparam int FB_LIM = 5;
	localparam int FB_HOME = 6;
	localparam int FB_SYNC = 7;
	localparam int NUM_FAULTS = 8;
	// fault bits that software cannot clear
	localparam logic [7:0] FAULT_STICKY = 8'h06;
	// emergency error codes
	localparam logic [15:0] EC_GUARD = 16'h8130;
	localparam logic [15:0] EC_INIT = 16'h8160;
	localparam logic [15:0] EC_STOP = 16'h8170;
	localparam logic [15:0] EC_NET = 16'h8141;
	localparam logic [15:0] EC_PDO = 16'h8210;
	localparam logic [15:0] EC_SETTING = 16'h6320;
	// reset values
	localparam logic [31:0] RST_ZERO = 32'h0000_0000;
	localparam logic [7:0] RST_BUSERR = 8'hFF;
	// sdo abort codes
	localparam logic [31:0] AB_TOGGLE = 32'h0503_0000;
	localparam logic [31:0] AB_TIMEOUT = 32'h0504_0000;
	localparam logic [31:0] AB_CMD = 32'h0504_0001;
	localparam logic [31:0] AB_MEM = 32'h0504_0005;
	localparam logic [31:0] AB_ACCESS = 32'h0601_0000;
	localparam logic [31:0] AB_RD_WO = 32'h0601_0001;
	localparam logic [31:0] AB_WR_RO = 32'h0601_0002;
	localparam logic [31:0] AB_NO_OBJ = 32'h0602_0000;
	localparam logic [31:0] AB_NOMAP = 32'h0604_0041;
	localparam logic [31:0] AB_MAPLEN = 32'h0604_0042;
	localparam logic [31:0] AB_PARAM = 32'h0604_0043;
	localparam logic [31:0] AB_DEVICE = 32'h0604_0047;
	localparam logic [31:0] AB_HW = 32'h0606_0000;
	localparam logic [31:0] AB_LEN = 32'h0607_0010;
	localparam logic [31:0] AB_LONG = 32'h0607_0012;
	localparam logic [31:0] AB_SHORT = 32'h0607_0013;
	localparam logic [31:0] AB_NO_SUB = 32'h0609_0011;
	localparam logic [31:0] AB_VALUE = 32'h0609_0030;
	localparam logic [31:0] AB_HIGH = 32'h0609_0031;
	localparam logic [31:0] AB_LOW = 32'h0609_0032;
	localparam logic [31:0] AB_MAXMIN = 32'h0609_0036;
	localparam logic [31:0] AB_GENERAL = 32'h0800_0000;
	localparam logic [31:0] AB_STORE = 32'h0800_0020;
	localparam logic [31:0] AB_LOCAL = 32'h0800_0021;
	localparam logic [31:0] AB_STATE = 32'h0800_0022;
	localparam logic [31:0] AB_OD = 32'h0800_0023;
	localparam logic [31:0] AB_NOVAL = 32'h0800_0024;
	// sdo condition bit positions, checked from low to high
	localparam int SC_CMD = 0;
	localparam int SC_TOGGLE = 1;
	localparam int SC_NO_OBJ = 2;
	localparam int SC_NO_SUB = 3;
	localparam int SC_ACCESS = 4;
	localparam int SC_RD_WO = 5;
	localparam int SC_WR_RO = 6;
	localparam int SC_NOMAP = 7;
	localparam int SC_MAPLEN = 8;
	localparam int SC_LEN = 9;
	localparam int SC_LONG = 10;
	localparam int SC_SHORT = 11;
	localparam int SC_VALUE = 12;
	localparam int SC_HIGH = 13;
	localparam int SC_LOW = 14;
	localparam int SC_MAXMIN = 15;
	localparam int SC_PARAM = 16;
	localparam int SC_DEVICE = 17;
	localparam int SC_HW = 18;
	localparam int SC_MEM = 19;
	localparam int SC_STORE = 20;
	localparam int SC_LOCAL = 21;
	localparam int SC_STATE = 22;
	localparam int SC_OD = 23;
	localparam int SC_NOVAL = 24;
	localparam int SC_GENERAL = 25;
	localparam int NUM_SC = 26;
	// timer tick: 1 ms at 25 MHz
	localparam int CLOCK_HZ = 25000000;
	localparam int TICK_US = 1000;
	localparam int TICK_CYCLES = CLOCK_HZ / 1000000 * TICK_US;
	// ahb transfer type
	localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
	typedef enum logic [1:0] {SDO_IDLE, SDO_BUSY, SDO_ABORT} cfa_sdo_state_t;
endpackage

// ==== test/cfa_master_model.sv ====
// behavioural bus master: sync and heartbeat producer
`timescale 1ns/1ns
module cfa_master_model
(
	input logic clock,
	input logic [15:0] syncPer,
	input logic [15:0] hbPer,
	output logic syncEvt,
	output logic heartbeatMsg
);
	logic [15:0] syncCnt;
	logic [15:0] hbCnt;
	initial {syncCnt, hbCnt, syncEvt, heartbeatMsg} = '0;
	////////////////////////////////////////////////////////////
	// sync at period
	always @(posedge clock)
	begin
		syncCnt <= (syncPer == 16'h0000 || syncCnt >= syncPer - 16'h0001) ? 16'h0000 : syncCnt + 16'h0001;
		syncEvt <= syncPer != 16'h0000 && syncCnt == syncPer - 16'h0001;
	end
	// zero period: producer silent, lets the watch expire
	always @(posedge clock)
	begin
		hbCnt <= (hbPer == 16'h0000 || hbCnt >= hbPer - 16'h0001) ? 16'h0000 : hbCnt + 16'h0001;
		heartbeatMsg <= hbPer != 16'h0000 && hbCnt == hbPer - 16'h0001;
	end
endmodule

// ==== test/cfa_fault_abort_monitor.sv ====
// assertion checker for the fault and abort block
`timescale 1ns/1ns
module cfa_fault_abort_monitor
	import cfa_pkg::*;
(
	input logic clock,
	input logic resetn,
	input logic motorEnabled,
	input logic nmtResetCmd,
	input logic nmtStopCmd,
	input logic sdoCheck,
	input logic [NUM_SC-1:0] sdoCond,
	input logic sdoAbort,
	input logic [31:0] sdoAbortCode,
	input logic sdoBusy,
	input logic [NUM_FAULTS-1:0] faultFlags,
	input logic [15:0] errorCode
);
	default clocking dc @(posedge clock);
	endclocking
	default disable iff (!resetn);
	////////////////////////////////////////////////////////////
	init_fault_a:
	assert property (motorEnabled && nmtResetCmd |=> faultFlags[FB_INIT]) else $error("init not flagged");
	stop_fault_a:
	assert property (motorEnabled && nmtStopCmd |=> faultFlags[FB_STOP]) else $error("stop not flagged");
	init_sticky_a:
	assert property (faultFlags[FB_INIT] |=> faultFlags[FB_INIT]) else $error("init fault cleared");
	cmd_abort_a:
	assert property (sdoBusy && sdoCheck && sdoCond[SC_CMD] |=> sdoAbort && sdoAbortCode == AB_CMD)
		else $error("bad command code");
	noobj_abort_a:
	assert property (sdoBusy && sdoCheck && sdoCond[SC_NO_OBJ:0] == 3'b100 |=> sdoAbortCode == AB_NO_OBJ)
		else $error("missing index code");
	abort_ends_a:
	assert property (sdoAbort |=> !sdoAbort && !sdoBusy) else $error("transfer not ended");
	abort_busy_a:
	assert property ($rose(sdoAbort) |-> $past(sdoBusy)) else $error("abort while idle");
	guard_code_a:
	assert property (faultFlags == 8'h01 |-> errorCode == EC_GUARD) else $error("guard code");
	init_code_a:
	assert property (faultFlags[FB_INIT] |-> errorCode == EC_INIT) else $error("init code");
	net_code_a:
	assert property (faultFlags[3:0] == 4'h8 |-> errorCode == EC_NET) else $error("net code");
	pdo_code_a:
	assert property (faultFlags[4:0] == 5'h10 |-> errorCode == EC_PDO) else $error("pdo code");
endmodule
bind cfa_fault_abort cfa_fault_abort_monitor i_cfa_fault_abort_monitor (.clock(clock), .resetn(resetn),
	.motorEnabled(motorEnabled), .nmtResetCmd(nmtResetCmd), .nmtStopCmd(nmtStopCmd), .sdoCheck(sdoCheck),
	.sdoCond(sdoCond), .sdoAbort(sdoAbort), .sdoAbortCode(sdoAbortCode), .sdoBusy(sdoBusy),
	.faultFlags(faultFlags), .errorCode(errorCode));

// ==== test/cfa_fault_abort_tb.sv ====
// self-checking bench for the fault and abort block
`timescale 1ns/1ns
module cfa_fault_abort_tb import cfa_pkg::*;;
	localparam logic [31:0] CODES [NUM_SC] = '{AB_CMD, AB_TOGGLE, AB_NO_OBJ, AB_NO_SUB, AB_ACCESS, AB_RD_WO,
		AB_WR_RO, AB_NOMAP, AB_MAPLEN, AB_LEN, AB_LONG, AB_SHORT, AB_VALUE, AB_HIGH, AB_LOW, AB_MAXMIN, AB_PARAM,
		AB_DEVICE, AB_HW, AB_MEM, AB_STORE, AB_LOCAL, AB_STATE, AB_OD, AB_NOVAL, AB_GENERAL};
	localparam int LO [4] = '{10, 10, 10, 200};
	localparam int HM [4] = '{50, 10, 100, 150};
	logic clock, resetn, hsel, hwrite, hready, hreadyout, hresp, motorEnabled, sdoToggle, sdoAbort, sdoBusy;
	logic syncEvt, heartbeatMsg, nmtResetCmd, nmtStopCmd, guardMsg, busErrorEvt, busOkEvt, pdoRxValid;
	logic sdoStart, sdoSegment, sdoDone, sdoCheck;
	logic [7:0] haddr;
	logic [1:0] htrans;
	logic [1:0] pdoRxNum;
	logic [2:0] hsize;
	logic [3:0] pdoRxLen;
	logic [9:0] ev;
	logic [15:0] errorCode, syncPer, hbPer;
	logic [31:0] hwdata, hrdata, sdoAbortCode;
	logic [NUM_SC-1:0] sdoCond;
	logic [NUM_FAULTS-1:0] faultFlags;
	int n_mismatch, compares, cycles;
	assign hready = hreadyout;
	assign {sdoSegment, sdoCheck, sdoDone, sdoStart, busOkEvt, busErrorEvt, guardMsg, nmtStopCmd, nmtResetCmd,
		pdoRxValid} = ev;
	always #20 clock = ~clock;
	// short tick keeps timer scenarios brief
	cfa_fault_abort #(.TICK_LEN(10)) i_cfa_fault_abort (.clock(clock), .resetn(resetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .motorEnabled(motorEnabled),
		.nmtResetCmd(nmtResetCmd), .nmtStopCmd(nmtStopCmd), .guardMsg(guardMsg), .heartbeatMsg(heartbeatMsg),
		.busErrorEvt(busErrorEvt), .busOkEvt(busOkEvt), .pdoRxValid(pdoRxValid), .pdoRxLen(pdoRxLen),
		.pdoRxNum(pdoRxNum), .syncEvt(syncEvt), .sdoStart(sdoStart), .sdoSegment(sdoSegment),
		.sdoToggle(sdoToggle), .sdoDone(sdoDone), .sdoCheck(sdoCheck), .sdoCond(sdoCond), .sdoAbort(sdoAbort),
		.sdoAbortCode(sdoAbortCode), .sdoBusy(sdoBusy), .faultFlags(faultFlags), .errorCode(errorCode));
	cfa_master_model i_cfa_master_model (.clock(clock), .syncPer(syncPer), .hbPer(hbPer), .syncEvt(syncEvt),
		.heartbeatMsg(heartbeatMsg));
	////////////////////////////////////////////////////////////
	task report_and_stop();
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("ERROR %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clock);
		{hsel, haddr, htrans, hwrite, hsize} <= {1'b1, a, HTRANS_NONSEQ, wr, 3'd2};
		do @(posedge clock); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge clock); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 32'h0000_0000, q);
		chk(q, exp);
	endtask
	task pulse(input logic [9:0] m);
		@(posedge clock);
		ev <= m;
		@(posedge clock);
		ev <= '0;
	endtask
	task settle(input int n);
		repeat (n) @(posedge clock);
		@(negedge clock);
	endtask
	task do_reset();
		@(posedge clock);
		resetn <= 1'b0;
		repeat (16) @(posedge clock);
		resetn <= 1'b1;
		settle(3);
	endtask
	function logic [1:0] exp_set(input int lo, input int hi, input int h);
		return {!(h > lo && h < hi), lo > hi};
	endfunction
	////////////////////////////////////////////////////////////
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 60000)
		begin
			n_mismatch++;
			report_and_stop();
		end
	end
	initial
	begin
		int lo, hi, h, n, len;
		{clock, resetn, hsel, haddr, htrans, hwrite, hsize, hwdata, motorEnabled, sdoToggle} = '0;
		{ev, pdoRxNum, pdoRxLen, sdoCond, syncPer, hbPer, n_mismatch, compares, cycles} = '0;
		void'($urandom(32'h8f1c));
		do_reset();
		chk(faultFlags, 8'h40);
		rd(OFS_BUSERR, 32'h0000_00FF);
		rd(8'h3C, RST_ZERO);
		$display("test reset done");
		for (int i = 0; i < 9; i++)
		begin
			lo = i < 4 ? LO[i] : $urandom % 256;
			hi = i < 4 ? 100 : $urandom % 256;
			h = i < 4 ? HM[i] : $urandom % 256;
			if (i == 8)
				{lo, hi, h} = {32'd10, 32'd100, 32'd50};
			wr(OFS_LIMLO, lo);
			wr(OFS_LIMHI, hi);
			wr(OFS_HOME, h);
			wr(OFS_FAULT, 32'h0000_00FF);
			settle(3);
			chk(faultFlags[6:5], exp_set(lo, hi, h));
		end
		$display("test limits done");
		wr(OFS_BUSERR, 32'h0000_0003);
		repeat (2) pulse(10'h010);
		settle(2);
		chk(faultFlags[FB_NET], 1'b0);
		pulse(10'h010);
		settle(2);
		chk(faultFlags[FB_NET], 1'b1);
		chk(errorCode, EC_NET);
		repeat (3) pulse(10'h020);
		wr(OFS_FAULT, 32'h0000_00FF);
		settle(2);
		chk(faultFlags, 8'h00);
		$display("test bus errors done");
		wr(OFS_PDOMAP, 32'h0000_8421);
		for (int i = 0; i < 10; i++)
		begin
			n = $urandom % 4;
			len = ($urandom % 2) ? (1 << n) : $urandom % 16;
			pdoRxNum <= 2'(n);
			pdoRxLen <= 4'(len);
			pulse(10'h001);
			settle(2);
			chk(faultFlags, {3'b000, len != (1 << n), 4'h0});
			if (len != (1 << n))
				chk(errorCode, EC_PDO);
			wr(OFS_FAULT, 32'h0000_00FF);
		end
		$display("test pdo done");
		hbPer <= 16'd20;
		wr(OFS_HBEAT, 32'h0000_0004);
		settle(100);
		wr(OFS_FAULT, 32'h0000_00FF);
		settle(60);
		chk(faultFlags, 8'h00);
		hbPer <= 16'd0;
		settle(100);
		chk(faultFlags, 8'h01);
		chk(errorCode, EC_GUARD);
		wr(OFS_HBEAT, RST_ZERO);
		wr(OFS_FAULT, 32'h0000_00FF);
		settle(2);
		chk(faultFlags, 8'h00);
		wr(OFS_GUARD, 32'h0000_0002);
		pulse(10'h008);
		settle(60);
		chk(faultFlags, 8'h01);
		wr(OFS_GUARD, RST_ZERO);
		wr(OFS_FAULT, 32'h0000_00FF);
		$display("test guard done");
		wr(OFS_SYNCPER, 32'h0000_0008);
		syncPer <= 16'd80;
		settle(300);
		wr(OFS_FAULT, 32'h0000_00FF);
		settle(300);
		chk(faultFlags[FB_SYNC], 1'b0);
		syncPer <= 16'd160;
		settle(400);
		chk(faultFlags[FB_SYNC], 1'b1);
		syncPer <= 16'd0;
		wr(OFS_SYNCPER, RST_ZERO);
		$display("test sync done");
		for (int i = 0; i < NUM_SC; i++)
		begin
			pulse(10'h040);
			sdoCond <= NUM_SC'(($urandom & ~((32'd2 << i) - 1)) | (32'd1 << i));
			pulse(10'h100);
			settle(2);
			chk(sdoAbortCode, CODES[i]);
			chk(sdoBusy, 1'b0);
		end
		rd(OFS_ABORT, AB_GENERAL);
		sdoCond <= '0;
		for (int i = 0; i < 4; i++)
		begin
			pulse(10'h040);
			sdoToggle <= 1'b0;
			pulse(10'h200);
			sdoToggle <= i[0];
			pulse(10'h200);
			settle(1);
			chk(sdoBusy, i[0]);
			pulse(10'h080);
			settle(2);
			chk(sdoAbortCode, AB_TOGGLE);
		end
		wr(OFS_SDOTMO, 32'h0000_0002);
		pulse(10'h040);
		settle(60);
		chk(sdoAbortCode, AB_TIMEOUT);
		chk(sdoBusy, 1'b0);
		$display("test sdo done");
		pulse(10'h006);
		settle(2);
		chk(faultFlags[2:1], 2'b00);
		@(posedge clock);
		motorEnabled <= 1'b1;
		pulse(10'h004);
		settle(2);
		chk(errorCode, EC_STOP);
		wr(OFS_FAULT, 32'h0000_00FF);
		pulse(10'h002);
		settle(2);
		chk(faultFlags[2:1], 2'b11);
		rd(OFS_ERRCODE, {16'h0000, EC_INIT});
		motorEnabled <= 1'b0;
		do_reset();
		chk(faultFlags, 8'h40);
		$display("test nmt done");
		report_and_stop();
	end
endmodule
